// ### shared/ldr_pkg.sv
// Constants for the display driver bus receiver and its helpers.
// Assumes a single 100 MHz system clock; nothing else is shared.
package ldr_pkg;

  // ----------------------------------------------------------------
  // Slave address
  // ----------------------------------------------------------------
  // Upper six address bits common to both slave addresses
  localparam logic [5:0] ADDR_PREFIX   = 6'h1C;
  localparam int         ADDR_SEL_POS  = 1;
  localparam int         ADDR_RW_POS   = 0;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         CONT_POS      = 7;
  localparam int         DATA_W        = 8;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  localparam int         CMD_PTR_POS   = 6;
  localparam logic [3:0] CMD_DEV_SEL   = 4'hC;

  // ----------------------------------------------------------------
  // Display RAM and data path
  // ----------------------------------------------------------------
  localparam int         RAM_DEPTH     = 40;
  localparam int         RAM_AW        = 6;
  localparam logic [5:0] RAM_LAST      = 6'h27;
  localparam logic [2:0] SUB_LAST      = 3'h7;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         FIFO_W        = RAM_AW + DATA_W;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] PTR_RST       = 6'h00;
  localparam logic [2:0] SUB_RST       = 3'h0;
  localparam logic [6:0] MODE_RST      = 7'h00;
  localparam logic [5:0] PINS_RST      = 6'h03;

  // Receiver states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA,
    ST_IGNORE
  } ldr_state_t;

endpackage

// ### hdl/ldr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module ldr_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign o_in_ready  = (cnt_r != FULL);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rd_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage has no reset; only counters need defined values
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
    begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  // Pointers wrap at D, which need not be a power of two
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_r <= (wr_r == AW'(D - 1)) ? '0 : wr_r + AW'(1);
      end
      if (pop)
      begin
        rd_r <= (rd_r == AW'(D - 1)) ? '0 : rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### hdl/ldr_ram.sv
// Display RAM: one write port, one read port with registered data.
// Assumes one clock; contents are undefined after power-up.
`timescale 1ns/10ps
module ldr_ram #(
  parameter int W  = 8,
  parameter int D  = 40,
  parameter int AW = 6
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_reset,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic [W-1:0]       o_rdata
);
  logic [W-1:0] mem_r [D];

  // Writes beyond the depth are dropped
  always_ff @(posedge i_clk_sys)
  begin
    if (i_we && (i_waddr < AW'(D)))
    begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Read data registered; out of range reads as zero
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rdata <= '0;
    end
    else
    begin
      o_rdata <= (i_raddr < AW'(D)) ? mem_r[i_raddr] : '0;
    end
  end
endmodule

// ### hdl/ldr_i2c_rx.sv
// Write-only two-wire bus slave receiver of a cascadable display driver.
// Assumes bus pins and strap pins are asynchronous to i_clk_sys and the
// clock runs far faster than the bus clock.
//
// Function
// [RULE1] Acts only as slave receiver; the sole output is acknowledge.
// [RULE2] Answers only the two slave addresses 0111000 and 0111001.
// [RULE3] Address bit 1 must equal the select strap, else transfer ignored.
// [RULE4] Read accesses are not answered; master sends bit 0 as zero.
// [RULE5] Every device with matching select strap acknowledges the address.
// [RULE6] Command bytes follow; a cleared top bit marks the final command.
// [RULE7] All addressed devices acknowledge every command byte.
// [RULE8] Later bytes are display data written at pointer, then pointers advance.
// [RULE9] Data is acknowledged only when subaddress counter equals the strap.
// [RULE10] Master ends with STOP or a repeated START.
// [RULE11] Data falling while clock high is START.
// [RULE12] Data rising while clock high is STOP.
// [RULE13] One bit per clock pulse; data stable while clock high.
// [RULE14] Each byte gets one acknowledge clock; byte count unlimited.
// [RULE15] Acknowledge holds data low across the whole acknowledge clock.
// [RULE16] Master starts only on an idle bus.
// [RULE17] Three subaddress pins form a binary subaddress, zero when all low.
// [RULE18] Controller executes commands, holds status, steers data into RAM.
// [RULE19] Subaddress strap stays constant during any access.
// [RULE20] Data past RAM end of the last device is dropped, not acknowledged.
// [RULE21] Bus lines are synchronised before edges and conditions are decoded.
`timescale 1ns/10ps
module ldr_i2c_rx (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic        i_address_select_pin,
  input  wire logic        i_subaddress_pin_bit0,
  input  wire logic        i_subaddress_pin_bit1,
  input  wire logic        i_subaddress_pin_bit2,
  input  wire logic        i_ram_hold,
  input  wire logic [5:0]  i_disp_raddr,
  output logic [7:0]       o_disp_rdata,
  output logic [6:0]       o_mode,
  output logic [5:0]       o_data_ptr,
  output logic [2:0]       o_sub_cnt,
  output logic             o_overflow,
  output logic             o_busy
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Filtered bit follows the synchroniser only when two stages agree
  function automatic logic [5:0] agree(input logic [5:0] a,
                                       input logic [5:0] b,
                                       input logic [5:0] cur);
    logic [5:0] same;
    same  = ~(a ^ b);
    agree = (a & same) | (cur & ~same);
  endfunction

  // Advance of the pointer pair; carry goes into the subaddress
  function automatic logic [9:0] advance(input logic [5:0] ptr,
                                         input logic [2:0] sub,
                                         input logic       ovf);
    logic [5:0] p;
    logic [2:0] s;
    logic       o;
    p = ptr + 6'h01;
    s = sub;
    o = ovf;
    if (ptr >= ldr_pkg::RAM_LAST)
    begin
      p = ldr_pkg::PTR_RST;
      if (sub == ldr_pkg::SUB_LAST)
      begin
        o = 1'b1;
      end
      else
      begin
        s = sub + 3'h1;
      end
    end
    advance = {o, s, p};
  endfunction

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync3_r;
  logic [5:0] pins_r;
  logic [5:0] prev_r;

  // Stage one feeds stage two and nothing else
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1_r <= ldr_pkg::PINS_RST;
      sync2_r <= ldr_pkg::PINS_RST;
      sync3_r <= ldr_pkg::PINS_RST;
      pins_r  <= ldr_pkg::PINS_RST;
      prev_r  <= ldr_pkg::PINS_RST;
    end
    else
    begin
      sync1_r <= {i_subaddress_pin_bit2, i_subaddress_pin_bit1,
                  i_subaddress_pin_bit0, i_address_select_pin, i_sda, i_scl};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pins_r  <= agree(sync2_r, sync3_r, pins_r); // see [RULE21]
      prev_r  <= pins_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------
  logic       scl;
  logic       sda;
  logic       sel_strap;
  logic [2:0] sub_strap;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;

  // Strap levels are taken from the filtered pins
  assign scl       = pins_r[0];
  assign sda       = pins_r[1];
  assign sel_strap = pins_r[2];
  assign sub_strap = pins_r[5:3];  // see [RULE17]
  assign scl_rise  = scl && !prev_r[0];
  assign scl_fall  = !scl && prev_r[0];
  // Data moving under a high clock is a condition, not a bit
  assign start_ev  = scl && prev_r[0] && prev_r[1] && !sda; // see [RULE11] [RULE13]
  assign stop_ev   = scl && prev_r[0] && !prev_r[1] && sda; // see [RULE12] [RULE13]

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  ldr_pkg::ldr_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic       ack_phase_r;
  logic       byte_done;
  logic       ack_end;
  logic       active;

  assign active    = (state_r != ldr_pkg::ST_IDLE) && (state_r != ldr_pkg::ST_IGNORE);
  assign byte_done = scl_fall && !ack_phase_r && (bit_cnt_r == ldr_pkg::BYTE_BITS);
  assign ack_end   = scl_fall && ack_phase_r;

  // Shift on rising clock; the ninth clock is the acknowledge slot
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      bit_cnt_r   <= '0;
      shift_r     <= '0;
      ack_phase_r <= 1'b0;
    end
    else if (start_ev || stop_ev)
    begin
      bit_cnt_r   <= '0;
      ack_phase_r <= 1'b0;
    end
    else
    begin
      if (scl_rise && !ack_phase_r && (bit_cnt_r != ldr_pkg::BYTE_BITS))
      begin
        shift_r   <= {shift_r[6:0], sda};            // see [RULE13]
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (byte_done)
      begin
        ack_phase_r <= 1'b1;                         // see [RULE14]
      end
      if (ack_end)
      begin
        ack_phase_r <= 1'b0;
        bit_cnt_r   <= '0;                           // see [RULE14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte classification
  // ----------------------------------------------------------------
  logic addr_hit;
  logic data_hit;
  logic fifo_in_ready;
  logic ack_dec;
  logic [5:0] ptr_r;
  logic [2:0] sub_r;
  logic       ovf_r;

  // Fixed prefix, strap on bit 1 and write direction only
  assign addr_hit = (shift_r[7:2] == ldr_pkg::ADDR_PREFIX)        // see [RULE2]
                  && (shift_r[ldr_pkg::ADDR_SEL_POS] == sel_strap) // see [RULE3]
                  && !shift_r[ldr_pkg::ADDR_RW_POS];               // see [RULE4]
  // Past the last device in a cascade nobody owns the byte
  assign data_hit = (sub_r == sub_strap) && !ovf_r                 // see [RULE9] [RULE20]
                  && (ptr_r <= ldr_pkg::RAM_LAST);

  // Decide acknowledge for the byte just completed
  always_comb
  begin
    ack_dec = 1'b0;
    unique case (state_r)
      ldr_pkg::ST_ADDR:   ack_dec = addr_hit;                  // see [RULE5]
      ldr_pkg::ST_CMD:    ack_dec = 1'b1;                      // see [RULE7]
      // A full FIFO refuses the byte by withholding acknowledge
      ldr_pkg::ST_DATA:   ack_dec = data_hit && fifo_in_ready; // see [RULE9]
      ldr_pkg::ST_IDLE:   ack_dec = 1'b0;
      ldr_pkg::ST_IGNORE: ack_dec = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  // A repeated START restarts from the address byte
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r <= ldr_pkg::ST_IDLE;
    end
    else if (start_ev)
    begin
      state_r <= ldr_pkg::ST_ADDR;                   // see [RULE11]
    end
    else if (stop_ev)
    begin
      state_r <= ldr_pkg::ST_IDLE;                   // see [RULE12]
    end
    else if (byte_done)
    begin
      unique case (state_r)
        ldr_pkg::ST_ADDR:
          state_r <= addr_hit ? ldr_pkg::ST_CMD : ldr_pkg::ST_IGNORE; // see [RULE3]
        ldr_pkg::ST_CMD:
          if (!shift_r[ldr_pkg::CONT_POS])
          begin
            state_r <= ldr_pkg::ST_DATA;             // see [RULE6]
          end
        ldr_pkg::ST_DATA:   state_r <= ldr_pkg::ST_DATA;
        ldr_pkg::ST_IDLE:   state_r <= ldr_pkg::ST_IDLE;
        ldr_pkg::ST_IGNORE: state_r <= ldr_pkg::ST_IGNORE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge driver
  // ----------------------------------------------------------------
  // Pull low from the fall after bit 8 to the fall after the ninth
  // clock, so the line is settled across the whole high phase
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
    end
    else
    begin
      o_sda_out <= 1'b0;                             // see [RULE1]
      if (start_ev || stop_ev || ack_end)
      begin
        o_sda_oe <= 1'b0;
      end
      else if (byte_done)
      begin
        o_sda_oe <= ack_dec;                         // see [RULE15]
      end
    end
  end

  // ----------------------------------------------------------------
  // Command execution and pointers
  // ----------------------------------------------------------------
  logic       cmd_exec;
  logic       data_byte;
  logic [9:0] adv;

  assign cmd_exec  = byte_done && (state_r == ldr_pkg::ST_CMD);
  assign data_byte = byte_done && (state_r == ldr_pkg::ST_DATA);
  assign adv       = advance(ptr_r, sub_r, ovf_r);

  // Every addressed device tracks the pointers so the cascade agrees
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      ptr_r  <= ldr_pkg::PTR_RST;
      sub_r  <= ldr_pkg::SUB_RST;
      ovf_r  <= 1'b0;
      o_mode <= ldr_pkg::MODE_RST;
    end
    else if (cmd_exec)
    begin
      if (!shift_r[ldr_pkg::CMD_PTR_POS])
      begin
        ptr_r <= shift_r[5:0];                       // see [RULE18]
        ovf_r <= 1'b0;
      end
      else if (shift_r[6:3] == ldr_pkg::CMD_DEV_SEL)
      begin
        sub_r <= shift_r[2:0];                       // see [RULE18]
        ovf_r <= 1'b0;
      end
      else
      begin
        o_mode <= shift_r[6:0];                      // see [RULE18]
      end
    end
    else if (data_byte && !ovf_r)
    begin
      {ovf_r, sub_r, ptr_r} <= adv;                  // see [RULE8] [RULE20]
    end
  end

  // ----------------------------------------------------------------
  // Data path: FIFO into display RAM
  // ----------------------------------------------------------------
  logic                        fifo_push;
  logic                        fifo_out_valid;
  logic [ldr_pkg::FIFO_W-1:0]  fifo_out_data;
  logic                        ram_we;

  // Only the owning device stores the byte
  assign fifo_push = data_byte && data_hit;          // see [RULE8] [RULE9]
  // Display side may stall the drain, which fills the FIFO
  assign ram_we    = fifo_out_valid && !i_ram_hold;

  ldr_fifo #(
    .W (ldr_pkg::FIFO_W),
    .D (ldr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({ptr_r, shift_r}),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (!i_ram_hold),
    .o_out_data  (fifo_out_data)
  );

  ldr_ram #(
    .W  (ldr_pkg::DATA_W),
    .D  (ldr_pkg::RAM_DEPTH),
    .AW (ldr_pkg::RAM_AW)
  ) u_ram (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_we      (ram_we),                             // see [RULE18]
    .i_waddr   (fifo_out_data[ldr_pkg::FIFO_W-1:ldr_pkg::DATA_W]),
    .i_wdata   (fifo_out_data[ldr_pkg::DATA_W-1:0]),
    .i_raddr   (i_disp_raddr),
    .o_rdata   (o_disp_rdata)
  );

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_data_ptr <= ldr_pkg::PTR_RST;
      o_sub_cnt  <= ldr_pkg::SUB_RST;
      o_overflow <= 1'b0;
      o_busy     <= 1'b0;
    end
    else
    begin
      o_data_ptr <= ptr_r;
      o_sub_cnt  <= sub_r;
      o_overflow <= ovf_r;
      o_busy     <= active || fifo_out_valid;
    end
  end

endmodule

// ### dv/ldr_bus_master.sv
// Bus master model for the two-wire link of the display driver.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
module ldr_bus_master #(
  parameter int HALF = 20
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // Idle bus: both lines released high
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // Start or repeated start; data raised first so a busy bus can restart
  task automatic bus_start();
    hw(HALF / 2);
    o_sda <= 1'b1;
    hw(HALF / 2);
    o_scl <= 1'b1;
    hw(HALF);
    o_sda <= 1'b0;
    hw(HALF);
    o_scl <= 1'b0;
  endtask

  // Byte MSB first; data only moves mid-low, ack sampled twice while high
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      hw(HALF / 2);
      o_sda <= b[i];
      hw(HALF / 2);
      o_scl <= 1'b1;
      hw(HALF);
      o_scl <= 1'b0;
    end
    hw(HALF / 2);
    o_sda <= 1'b1;
    hw(HALF / 2);
    o_scl <= 1'b1;
    hw(1);
    ack = (i_sda === 1'b0);
    hw(HALF - 2);
    ack = ack && (i_sda === 1'b0);
    hw(1);
    o_scl <= 1'b0;
  endtask

  // Stop: data rises while the clock is high
  task automatic bus_stop();
    hw(HALF / 2);
    o_sda <= 1'b0;
    hw(HALF / 2);
    o_scl <= 1'b1;
    hw(HALF);
    o_sda <= 1'b1;
    hw(HALF);
  endtask
endmodule

// ### dv/ldr_rx_checker.sv
// Port checker for the display driver bus receiver.
// Assumes it is bound to ldr_i2c_rx and that SCL phases last 8+ clocks.
`timescale 1ns/10ps
module ldr_rx_checker (
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  input wire logic       i_scl,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic [5:0] i_disp_raddr,
  input wire logic [7:0] o_disp_rdata,
  input wire logic [6:0] o_mode,
  input wire logic [5:0] o_data_ptr,
  input wire logic [2:0] o_sub_cnt,
  input wire logic       o_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // ---------------------------------------
  // Acknowledge drive
  // ---------------------------------------
  AST_DRIVE_ZERO_ONLY:
    assert property (o_sda_out == 1'b0) else $error("data out not zero");
  AST_ACK_RISE_LOW:
    assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("ack raised outside clock low");
  AST_ACK_FALL_LOW:
    assert property ($fell(o_sda_oe) |-> !i_scl) else $error("ack dropped while clock high");
  AST_ACK_STEADY_HIGH:
    assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("ack moved while clock high");
  AST_ACK_BOUNDED:
    assert property ($rose(o_sda_oe) |-> ##[8:1000] !o_sda_oe) else $error("ack too long");
  AST_ACK_NEEDS_BUSY:
    assert property (o_sda_oe |-> o_busy) else $error("ack while not addressed");

  // ---------------------------------------
  // Controller state and display read
  // ---------------------------------------
  AST_MODE_IDLE_STABLE:
    assert property (!o_busy && !$past(o_busy) |-> $stable(o_mode))
    else $error("mode moved while idle");
  AST_PTR_IDLE_STABLE:
    assert property (!o_busy && !$past(o_busy) |-> $stable(o_data_ptr) && $stable(o_sub_cnt))
    else $error("pointers moved while idle");
  AST_READ_PAST_END:
    assert property ((i_disp_raddr > 6'h27) [*3] |-> o_disp_rdata == 8'h00)
    else $error("read past end not zero");

  COV_ACK: cover property ($rose(o_sda_oe));
  COV_SUB_STEP: cover property ($changed(o_sub_cnt));
  COV_DONE: cover property ($fell(o_busy));
endmodule

bind ldr_i2c_rx ldr_rx_checker u_chk (
  .i_clk_sys    (i_clk_sys),
  .i_reset      (i_reset),
  .i_scl        (i_scl),
  .o_sda_out    (o_sda_out),
  .o_sda_oe     (o_sda_oe),
  .i_disp_raddr (i_disp_raddr),
  .o_disp_rdata (o_disp_rdata),
  .o_mode       (o_mode),
  .o_data_ptr   (o_data_ptr),
  .o_sub_cnt    (o_sub_cnt),
  .o_busy       (o_busy)
);

// ### dv/test_ldr_i2c_rx.sv
// Self-checking bench for the display driver bus receiver.
// Assumes the master model and a pulled-up open-drain data wire.
`timescale 1ns/10ps
module test_ldr_i2c_rx;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sel = 1'b0;
  logic [2:0] sub = 3'h0;
  logic       hold = 1'b0;
  logic [5:0] raddr = 6'h00;
  logic       scl, msda, sda, oe, sda_out, ovf, busy;
  logic [7:0] rdata;
  logic [6:0] mode;
  logic [5:0] ptr;
  logic [2:0] subc;
  int         bad_count = 0;
  int         samples_checked = 0;

  // Pull-up: low whenever any party pulls
  assign sda = msda & (oe ? sda_out : 1'b1);
  always #5 clk = ~clk;

  ldr_bus_master m (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
  ldr_i2c_rx dut (
    .i_clk_sys(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(oe), .i_address_select_pin(sel),
    .i_subaddress_pin_bit0(sub[0]), .i_subaddress_pin_bit1(sub[1]),
    .i_subaddress_pin_bit2(sub[2]), .i_ram_hold(hold), .i_disp_raddr(raddr),
    .o_disp_rdata(rdata), .o_mode(mode), .o_data_ptr(ptr), .o_sub_cnt(subc),
    .o_overflow(ovf), .o_busy(busy)
  );

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    m.put_byte(b, a);
    chk("ack", {31'h0, a}, {31'h0, exp_ack});
  endtask

  // Read back waits past the registered read path; looks mid-cycle
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    raddr <= a;
    m.hw(2);
    @(negedge clk);
    chk("ram", {24'h0, rdata}, {24'h0, e});
    m.hw(1);
  endtask

  // Address table: {strap, ack expected, address byte}
  task automatic t_address();
    logic [9:0] tbl [6] = '{10'h170, 10'h072, 10'h071, 10'h060, 10'h372, 10'h270};
    foreach (tbl[i])
    begin
      sel <= tbl[i][9];
      m.bus_start();
      send(tbl[i][7:0], tbl[i][8]);
      send(8'h80, tbl[i][8]);
      // Even entries end in a repeated start, odd ones in a stop
      if (i % 2 == 1)
      begin
        m.bus_stop();
      end
    end
  endtask

  // Three commands, then data across the subaddress boundary
  task automatic t_cmd_data();
    sel <= 1'b0;
    m.bus_start();
    send(8'h70, 1'b1);
    send(8'hE0, 1'b1);
    send(8'hCA, 1'b1);
    send(8'h26, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b0);
    m.bus_stop();
    m.hw(20);
    chk("mode", {25'h0, mode}, 32'h4A);
    chk("ptr", {26'h0, ptr}, 32'h1);
    chk("sub", {29'h0, subc}, 32'h1);
    rd(6'h26, 8'h11);
    rd(6'h27, 8'h22);
    rd(6'h30, 8'h00);
  endtask

  // Last device, last address, then one byte too many
  task automatic t_overflow();
    sub <= 3'h7;
    m.bus_start();
    send(8'h70, 1'b1);
    send(8'hA7, 1'b1);
    send(8'h67, 1'b1);
    send(8'h44, 1'b1);
    send(8'h55, 1'b0);
    m.bus_stop();
    chk("overflow", {31'h0, ovf}, 32'h1);
    rd(6'h27, 8'h44);
  endtask

  // Stalled drain: buffer fills to eight, ninth byte is refused
  task automatic t_fifo();
    sub <= 3'h0;
    hold <= 1'b1;
    m.bus_start();
    send(8'h70, 1'b1);
    send(8'h80, 1'b1);
    send(8'h60, 1'b1);
    for (int i = 0; i < 9; i++)
      send(8'hA0 + 8'(i), i < 8);
    m.bus_stop();
    chk("busy held", {31'h0, busy}, 32'h1);
    hold <= 1'b0;
    m.hw(30);
    chk("busy drained", {31'h0, busy}, 32'h0);
    for (int i = 0; i < 8; i++)
      rd(6'(i), 8'hA0 + 8'(i));
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    m.hw(10);
    t_address();
    t_cmd_data();
    t_overflow();
    t_fifo();
    report_and_stop();
  end

  // Watchdog well above the expected run of some 14000 clocks
  initial
  begin
    #800000;
    bad_count++;
    report_and_stop();
  end
endmodule
